// file: src/config_port_status_regs.vh
// Constants for the configuration port status monitor.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef CONFIG_PORT_STATUS_REGS_VH
`define CONFIG_PORT_STATUS_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CONTROL        8'h00
`define OFS_STATUS         8'h04
`define OFS_IRQ_STATUS     8'h08
`define OFS_IRQ_MASK       8'h0c

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_FAMILY_BIT    0
`define CTRL_RESET         1'h0
`define IRQ_MASK_RESET     4'h0
`define STATUS_RESET       32'h0000009f
`define EVT_SYNC_BIT       0
`define EVT_CRC_ERR_BIT    1
`define EVT_CRC_RESET_BIT  2
`define EVT_DESYNCHRONIZE_CMD_BIT     3
`define ST_ERROR_N_BIT     7
`define ST_ALIGNED_BIT     6
`define ST_READBACK_BIT    5
`define ST_ABORT_N_BIT     4
`define RSVD_NIBBLE_OLD    4'hf
`define RSVD_NIBBLE_NEW    4'hb

// ----------------------------------------------------------------
// Bitstream words recognised on the write side
// ----------------------------------------------------------------
`define SYNC_WORD          32'haa995566
`define CMD_WRITE_HEADER   32'h30008001
`define CMD_CRC_RESET      32'h00000007
`define CMD_DESYNCHRONIZE_CMD         32'h0000000d

`endif

// file: src/config_word_decoder.v
// Decoder of bitstream words written into the configuration port.
// Assumes words and valid come from fabric logic on the same clock.
`include "config_port_status_regs.vh"

module config_word_decoder
(
    // Clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // Word stream
    input  wire [31:0] cfgWord,
    input  wire        cfgWordValid,
    input  wire        aligned,
    // Decoded pulses
    output reg         syncSeen,
    output reg         crcResetSeen,
    output reg         desyncSeen
);

    reg expectCmd_reg;

    // ----------------------------------------------------------------
    // Word recognition
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            expectCmd_reg <= 1'b0;
            syncSeen      <= 1'b0;
            crcResetSeen  <= 1'b0;
            desyncSeen    <= 1'b0;
        end
        else
        begin
            syncSeen     <= 1'b0;
            crcResetSeen <= 1'b0;
            desyncSeen   <= 1'b0;
            if (cfgWordValid)
            begin
                if (!aligned)
                begin
                    // Same framing as the external parallel port
                    syncSeen      <= (cfgWord == `SYNC_WORD);
                    expectCmd_reg <= 1'b0;
                end
                else if (expectCmd_reg)
                begin
                    crcResetSeen  <= (cfgWord == `CMD_CRC_RESET);
                    desyncSeen    <= (cfgWord == `CMD_DESYNCHRONIZE_CMD);
                    expectCmd_reg <= 1'b0;
                end
                else
                begin
                    expectCmd_reg <= (cfgWord == `CMD_WRITE_HEADER);
                end
            end
        end
    end

endmodule

// file: src/config_port_status_monitor.v
// Status side of the internal configuration port, with APB registers.
// Assumes one 10 MHz clock; done pin arrives asynchronously from outside.
//
// Summary of operation
// - Status output is 32 bits; only the low byte is defined.
// - Bit 7 is low once a configuration error happened, else high.
// - Bit 6 is high after the sync word is received.
// - Bit 5 is high while readback is in progress.
// - Bit 4 is low while an abort is in progress.
// - Bits 3..0 reserved; read F on older family, B on newer.
// - Upper nibble: 9 idle, D synced, 5 synced with error, 1 error.
// - Status 0x9F before load, 0xDF once sync word accepted.
// - CRC error shows 0x5F one cycle, then 0x1F; init pin pulled low.
// - Partial error output low on any whole-file or per-frame CRC error.
// - Reload after error: sync word moves status 0x1F to 0x5F.
// - CRC-reset clears error, releases init pin, status 0x5F to 0xDF.
// - Desynchronize without error moves status 0xDF to 0x9F.
// - Partial-done output echoes the external configuration-done pin.
// - Port uses the same word protocol as the parallel interface.
//
// Design decisions made here: the register addresses and the APB slave port.
`include "config_port_status_regs.vh"

module config_port_status_monitor
(
    // Clock and reset
    input  wire        clock,
    input  wire        rst_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Bitstream word stream
    input  wire [31:0] cfgWord,
    input  wire        cfgWordValid,
    // Configuration engine events
    input  wire        crcFileError,
    input  wire        crcFrameError,
    input  wire        readbackActive,
    input  wire        abortActive,
    // External pins
    input  wire        configDonePin,
    output reg         initErrorOut,
    output reg         initErrorOe,
    // Status and dedicated outputs
    output reg  [31:0] statusOut,
    output reg         partialDoneOut,
    output reg         partialErrorOut,
    output reg         irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg        aligned_reg;
    reg        aligned_next;
    reg        cfgError_reg;
    reg        cfgError_next;
    reg        dropSync_reg;
    reg        dropSync_next;
    reg        family_reg;
    reg [3:0]  irqStatus_reg;
    reg [3:0]  irqStatus_next;
    reg [3:0]  irqMask_reg;
    reg        doneMeta_reg;
    reg        doneSync_reg;
    reg [31:0] status_next;
    reg [31:0] readData;
    reg        addrOk;
    reg [3:0]  events;

    wire syncSeen;
    wire crcResetSeen;
    wire desyncSeen;
    wire crcError;
    wire busDone;
    wire busWrite;
    wire busRead;

    assign crcError = crcFileError | crcFrameError;
    assign busDone  = psel & penable & pready;
    assign busWrite = busDone & pwrite;
    assign busRead  = busDone & ~pwrite;

    // ----------------------------------------------------------------
    // Word decoder
    // ----------------------------------------------------------------
    config_word_decoder wordDecoder
    (
        .clock        (clock),
        .rst_n        (rst_n),
        .cfgWord      (cfgWord),
        .cfgWordValid (cfgWordValid),
        .aligned      (aligned_reg),
        .syncSeen     (syncSeen),
        .crcResetSeen (crcResetSeen),
        .desyncSeen   (desyncSeen)
    );

    function [3:0] reservedNibble;
        input newFamily;
        begin
            reservedNibble = newFamily ? `RSVD_NIBBLE_NEW : `RSVD_NIBBLE_OLD;
        end
    endfunction

    function isOffset;
        input [7:0] addr;
        input [7:0] offset;
        begin
            isOffset = (addr == offset);
        end
    endfunction

    // ----------------------------------------------------------------
    // Sync and error tracking
    // ----------------------------------------------------------------
    always @*
    begin
        aligned_next  = aligned_reg;
        cfgError_next = cfgError_reg;
        dropSync_next = 1'b0;
        if (dropSync_reg)
        begin
            aligned_next = 1'b0;
        end
        if (syncSeen)
        begin
            aligned_next = 1'b1;
        end
        if (crcResetSeen)
        begin
            cfgError_next = 1'b0;
        end
        if (desyncSeen)
        begin
            aligned_next = 1'b0;
        end
        if (crcError)
        begin
            // Error wins over a same-cycle CRC reset
            cfgError_next = 1'b1;
            dropSync_next = aligned_next;
        end
    end

    // ----------------------------------------------------------------
    // Status byte
    // ----------------------------------------------------------------
    always @*
    begin
        status_next = 32'h00000000;
        status_next[`ST_ERROR_N_BIT]  = ~cfgError_next;
        status_next[`ST_ALIGNED_BIT]  = aligned_next;
        status_next[`ST_READBACK_BIT] = readbackActive;
        status_next[`ST_ABORT_N_BIT]  = ~abortActive;
        status_next[3:0] = reservedNibble(family_reg);
    end

    // ----------------------------------------------------------------
    // Interrupt events
    // ----------------------------------------------------------------
    always @*
    begin
        events = 4'h0;
        events[`EVT_SYNC_BIT]      = syncSeen;
        events[`EVT_CRC_ERR_BIT]   = crcError;
        events[`EVT_CRC_RESET_BIT] = crcResetSeen;
        events[`EVT_DESYNCHRONIZE_CMD_BIT]    = desyncSeen & ~cfgError_reg;
        irqStatus_next = irqStatus_reg;
        if (busRead && isOffset(paddr, `OFS_IRQ_STATUS))
        begin
            // Clear only what the read returned
            irqStatus_next = irqStatus_reg & ~prdata[3:0];
        end
        // Set wins over the read clear
        irqStatus_next = irqStatus_next | events;
    end

    // ----------------------------------------------------------------
    // Register read decode
    // ----------------------------------------------------------------
    always @*
    begin
        readData = 32'h00000000;
        addrOk   = 1'b1;
        case (paddr)
            `OFS_CONTROL:
            begin
                readData[`CTRL_FAMILY_BIT] = family_reg;
            end
            `OFS_STATUS:
            begin
                readData = statusOut;
            end
            `OFS_IRQ_STATUS:
            begin
                readData[3:0] = irqStatus_reg;
            end
            `OFS_IRQ_MASK:
            begin
                readData[3:0] = irqMask_reg;
            end
            default:
            begin
                addrOk = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // APB slave, one access cycle
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= 32'h00000000;
            family_reg  <= `CTRL_RESET;
            irqMask_reg <= `IRQ_MASK_RESET;
        end
        else
        begin
            pready <= psel & ~penable & ~pready;
            if (psel && !penable)
            begin
                prdata  <= pwrite ? 32'h00000000 : readData;
                pslverr <= ~addrOk;
            end
            else if (busDone)
            begin
                prdata  <= 32'h00000000;
                pslverr <= 1'b0;
            end
            if (busWrite && isOffset(paddr, `OFS_CONTROL))
            begin
                family_reg <= pwdata[`CTRL_FAMILY_BIT];
            end
            if (busWrite && isOffset(paddr, `OFS_IRQ_MASK))
            begin
                irqMask_reg <= pwdata[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Status registers and outputs
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aligned_reg     <= 1'b0;
            cfgError_reg    <= 1'b0;
            dropSync_reg    <= 1'b0;
            irqStatus_reg   <= 4'h0;
            statusOut       <= `STATUS_RESET;
            irq             <= 1'b0;
            partialErrorOut <= 1'b1;
            initErrorOut    <= 1'b0;
            initErrorOe     <= 1'b0;
        end
        else
        begin
            aligned_reg     <= aligned_next;
            cfgError_reg    <= cfgError_next;
            dropSync_reg    <= dropSync_next;
            irqStatus_reg   <= irqStatus_next;
            statusOut       <= status_next;
            irq             <= |(irqStatus_next & irqMask_reg);
            partialErrorOut <= ~cfgError_next;
            initErrorOut    <= 1'b0;
            initErrorOe     <= cfgError_next;
        end
    end

    // ----------------------------------------------------------------
    // Done pin synchroniser
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            doneMeta_reg   <= 1'b0;
            doneSync_reg   <= 1'b0;
            partialDoneOut <= 1'b0;
        end
        else
        begin
            doneMeta_reg   <= configDonePin;
            doneSync_reg   <= doneMeta_reg;
            partialDoneOut <= doneSync_reg;
        end
    end

endmodule

// file: testbench/config_port_status_monitor_assertions.sv
// Checker for the configuration port status monitor.
// Assumes binding to the top module and the shared header.
`include "config_port_status_regs.vh"

module config_port_status_monitor_assertions (
    // Clock and reset
    input logic        clock,
    input logic        rst_n,
    // APB
    input logic        psel,
    input logic        penable,
    input logic        pready,
    input logic [31:0] prdata,
    // Words and engine
    input logic [31:0] cfgWord,
    input logic        cfgWordValid,
    input logic        crcFileError,
    input logic        crcFrameError,
    input logic        readbackActive,
    input logic        abortActive,
    input logic        configDonePin,
    // Outputs
    input logic        initErrorOe,
    input logic [31:0] statusOut,
    input logic        partialDoneOut,
    input logic        partialErrorOut
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire crcAny = crcFileError | crcFrameError;
    // ----------
    // Sequences
    // ----------
    sequence s_sync;
        cfgWordValid && cfgWord == `SYNC_WORD && !statusOut[6] && !crcAny;
    endsequence
    sequence s_errShow;
        statusOut[7:4] == 4'h5 ##1 statusOut[7:4] == 4'h1;
    endsequence
    // ----------
    // Properties
    // ----------
    property p_upper; statusOut[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper)
        else $error("status upper bits set");
    property p_errPins;
        statusOut[7] == partialErrorOut && initErrorOe == !partialErrorOut;
    endproperty
    a_errPins: assert property (p_errPins)
        else $error("error bit and error pins disagree");
    property p_sync; s_sync ##1 !crcAny ##1 !crcAny |=> statusOut[6]; endproperty
    a_sync: assert property (p_sync)
        else $error("sync word did not align");
    property p_crc; crcAny && statusOut[7:6] == 2'b11 |=> s_errShow; endproperty
    a_crc: assert property (p_crc)
        else $error("crc error sequence wrong");
    property p_rip; $stable(readbackActive) |-> statusOut[5] == readbackActive; endproperty
    a_rip: assert property (p_rip)
        else $error("readback bit wrong");
    property p_abort; $stable(abortActive) |-> statusOut[4] == !abortActive; endproperty
    a_abort: assert property (p_abort)
        else $error("abort bit wrong");
    property p_done; partialDoneOut == $past(configDonePin, 3); endproperty
    a_done: assert property (p_done)
        else $error("partial done not echoing pin");
    property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
    a_apb: assert property (p_apb)
        else $error("ready not one cycle after setup");
    property p_rdZero; !pready |-> prdata == 32'h0; endproperty
    a_rdZero: assert property (p_rdZero)
        else $error("read data outside access");
endmodule

// file: testbench/config_fabric_loader.sv
// Fabric loader model pushing bitstream words into the port.
// Assumes calls just after a rising clock edge.
`include "config_port_status_regs.vh"

module config_fabric_loader (
    // Clock
    input  logic        clock,
    // Word stream
    output logic [31:0] cfgWord,
    output logic        cfgWordValid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        cfgWord = 32'h0;
        cfgWordValid = 1'b0;
    end
    // One word; released bus shows the inverse
    task send(input logic [31:0] w);
        cfgWordValid <= 1'b1;
        cfgWord <= w;
        @(posedge clock);
        cfgWordValid <= 1'b0;
        cfgWord <= ~w;
    endtask
    // Header and command back to back
    task sendCmd(input logic [31:0] c);
        cfgWordValid <= 1'b1;
        cfgWord <= `CMD_WRITE_HEADER;
        @(posedge clock);
        send(c);
    endtask
endmodule

// file: testbench/config_port_status_monitor_test.sv
// Self-checking bench for the configuration port status monitor.
// Assumes the loader model and checker compile first.
`include "config_port_status_regs.vh"

module config_port_status_monitor_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, cfgWord, statusOut, rd, w;
    logic        pready, pslverr, cfgWordValid, initErrorOut, initErrorOe, er;
    logic        partialDoneOut, partialErrorOut, irq, crcFileError = 0;
    logic        crcFrameError = 0, readbackActive = 0, abortActive = 0;
    logic        configDonePin = 0;
    logic [1:0]  act;
    logic [7:0]  ex;
    int          errTotal = 0, numChecks = 0, cycles = 0;
    // Action (0 word, 1 file crc, 2 frame crc, 3 command), word, status
    localparam logic [41:0] ROWS [9] = '{
        {2'd3, `CMD_CRC_RESET, 8'h9f},
        {2'd0, `SYNC_WORD, 8'hdf},
        {2'd1, 32'h0, 8'h1f},
        {2'd0, `SYNC_WORD, 8'h5f},
        {2'd3, `CMD_CRC_RESET, 8'hdf},
        {2'd2, 32'h0, 8'h1f},
        {2'd0, `SYNC_WORD, 8'h5f},
        {2'd3, `CMD_CRC_RESET, 8'hdf},
        {2'd3, `CMD_DESYNCHRONIZE_CMD, 8'h9f}
    };
    config_port_status_monitor u_dut (
        .clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cfgWord, .cfgWordValid, .crcFileError, .crcFrameError,
        .readbackActive, .abortActive, .configDonePin, .initErrorOut, .initErrorOe,
        .statusOut, .partialDoneOut, .partialErrorOut, .irq
    );
    config_fabric_loader u_fab (.clock, .cfgWord, .cfgWordValid);
    always #50 clock = ~clock;
    // ----------
    // Tasks
    // ----------
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e)
        begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task printVerdict;
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            errTotal++;
            printVerdict;
        end
    end
    // ----------
    // Sequence
    // ----------
    initial
    begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk("status", 32'h9f, statusOut);
        chk("oe", 0, 32'(initErrorOe));
        chk("pin", 0, 32'(initErrorOut));
        chk("perr", 1, 32'(partialErrorOut));
        chk("done", 0, 32'(partialDoneOut));
        chk("irq", 0, 32'(irq));
        chk("ready", 0, 32'(pready));
        apb(0, `OFS_IRQ_MASK, 0);
        chk("mask", 0, rd);
        foreach (ROWS[i])
        begin
            {act, w, ex} = ROWS[i];
            if (act == 2'd0)
                u_fab.send(w);
            else if (act == 2'd3)
                u_fab.sendCmd(w);
            else
            begin
                crcFileError <= act[0];
                crcFrameError <= act[1];
                @(posedge clock);
                crcFileError <= 1'b0;
                crcFrameError <= 1'b0;
            end
            repeat (3) @(posedge clock);
            chk("status", {24'h0, ex}, statusOut);
            chk("perr", 32'(ex[7]), 32'(partialErrorOut));
            chk("oe", 32'(!ex[7]), 32'(initErrorOe));
        end
        chk("irq", 0, 32'(irq));
        apb(0, `OFS_IRQ_STATUS, 0);
        chk("irqst", 32'hf, rd);
        apb(0, `OFS_IRQ_STATUS, 0);
        chk("irqclr", 0, rd);
        apb(1, `OFS_IRQ_MASK, 1);
        // Sync event lands between the clearing read's setup and completion
        fork
            u_fab.send(`SYNC_WORD);
            begin
                @(posedge clock);
                apb(0, `OFS_IRQ_STATUS, 0);
            end
        join
        chk("irqrace", 0, rd);
        repeat (3) @(posedge clock);
        chk("irq", 1, 32'(irq));
        apb(0, `OFS_IRQ_STATUS, 0);
        chk("irqkeep", 1, rd);
        repeat (2) @(posedge clock);
        chk("irq", 0, 32'(irq));
        u_fab.sendCmd(`CMD_DESYNCHRONIZE_CMD);
        repeat (3) @(posedge clock);
        apb(1, `OFS_CONTROL, 1);
        apb(0, `OFS_STATUS, 0);
        chk("status", 32'h9b, rd);
        apb(0, `OFS_CONTROL, 0);
        chk("ctl", 1, rd);
        apb(0, 8'h10, 0);
        chk("slverr", 1, 32'(er));
        chk("unmapped", 0, rd);
        readbackActive <= 1'b1;
        abortActive <= 1'b1;
        configDonePin <= 1'b1;
        repeat (4) @(posedge clock);
        chk("status", 32'hab, statusOut);
        chk("done", 1, 32'(partialDoneOut));
        printVerdict;
    end
endmodule

bind config_port_status_monitor config_port_status_monitor_assertions u_chk (
    .clock, .rst_n, .psel, .penable, .pready, .prdata, .cfgWord, .cfgWordValid,
    .crcFileError, .crcFrameError, .readbackActive, .abortActive, .configDonePin,
    .initErrorOe, .statusOut, .partialDoneOut, .partialErrorOut
);
